//--- fid_defs.svh
// Purpose: shared constants of the identification and discovery-table readout
// Assumes: included by bare name
// Notes:   values are the device's; opcodes are configurable defaults
`ifndef FID_DEFS_SVH
`define FID_DEFS_SVH

`define FID_LANES          4
`define FID_BYTE_BITS      4'h8
`define FID_CMD_BITS       5'h08
`define FID_ADDR_BITS      5'h18
`define FID_DUMMY_STD      5'h08
`define FID_DUMMY_QUAD     5'h0a
`define FID_TBL_AW         11
`define FID_TBL_HDR_END    11'h00f
`define FID_TBL_PARAM_BASE 11'h030
`define FID_TBL_PARAM_END  11'h053
`define FID_TBL_PARAM_CNT  36
`define FID_TBL_HDR_CNT    16
`define FID_FILL           8'hff
`define FID_ID_PAST        8'h00
`define FID_ID_LEN_SINGLE  11'h014
`define FID_ID_LEN_MULTI   11'h003
`define FID_UID_LEN_BYTE   8'h10
`define FID_OP_CLR_FLAGS   8'hc1
`define FID_OP_ID_SINGLE   8'hc2
`define FID_OP_ID_MULTI    8'hc3
`define FID_OP_TABLE       8'hc4

`endif

//--- fid_host_model.sv
// Purpose: serial host driving select, serial clock and data lanes
// Assumes: serial clock of 64 ns, stopped low outside frames
// Notes:   host lanes toggle while released; undriven device lanes read inverted
`timescale 1ns/100ps
module fid_host_model (
    input  wire logic [3:0] dut_dq_i,
    input  wire logic [3:0] dut_oe_i,
    output logic            sel_n_o,
    output logic            sclk_o,
    output logic      [3:0] dq_o,
    output logic      [3:0] oe_seen_o
);
    logic [3:0] bus_w;
    // a lane the device does not drive shows the inverse, so a missing drive cannot pass
    assign bus_w = dut_dq_i ~^ dut_oe_i;
    initial begin
        sel_n_o   = 1'b1;
        sclk_o    = 1'b0;
        dq_o      = 4'h0;
        oe_seen_o = 4'h0;
    end
    task automatic open_frame();
        #32 sel_n_o = 1'b0;
        oe_seen_o = 4'h0;
        #32;
    endtask : open_frame
    // select may rise anywhere, mid-byte included
    task automatic close_frame();
        #32 sel_n_o = 1'b1;
        #64;
    endtask : close_frame
    // iw lanes driven msb first, 0 releases them; ow lanes sampled from lane osh
    task automatic clocks(input logic [31:0] v, input int n, input int iw, input int ow, input int osh,
                          output logic [31:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            dq_o = (iw == 0) ? ~dq_o : 4'((v >> (i * iw)) & ((1 << iw) - 1));
            #32 sclk_o = 1'b1;
            r = (r << ow) | 32'((bus_w >> osh) & ((1 << ow) - 1));
            oe_seen_o = oe_seen_o | dut_oe_i;
            #32 sclk_o = 1'b0;
        end
    endtask : clocks
endmodule : fid_host_model

//--- fid_pkg.sv
// Purpose: types of the identification and discovery-table readout
// Assumes: nothing
// Notes:   no constants here, see fid_defs.svh
package fid_pkg;

    typedef enum logic [1:0] {
        FID_PROTO_EXT  = 2'h0,
        FID_PROTO_DUAL = 2'h1,
        FID_PROTO_QUAD = 2'h2
    } fid_proto_type;

    // gray along cmd -> addr -> dummy -> data
    typedef enum logic [2:0] {
        FID_ST_CMD    = 3'h0,
        FID_ST_ADDR   = 3'h1,
        FID_ST_DUMMY  = 3'h3,
        FID_ST_DATA   = 3'h7,
        FID_ST_IGNORE = 3'h4
    } fid_state_type;

    typedef enum logic [1:0] {
        FID_SRC_ID_SINGLE = 2'h0,
        FID_SRC_ID_MULTI  = 2'h1,
        FID_SRC_TABLE     = 2'h2
    } fid_src_type;

endpackage : fid_pkg

//--- fid_readout.sv
// Purpose: flag-clear, identification reads and discovery-table read of a serial flash
// Assumes: host drives select, serial clock and lanes; pins are asynchronous to clk_i
// Notes:   serial clock must be well below clk_i/4; data changes on falling serial edges
`timescale 1ns/100ps
`include "fid_defs.svh"
module fid_readout #(
    parameter logic [7:0]   MANUF_CODE    = 8'h5a,  // arbitrary value
    parameter logic [7:0]   MEM_TYPE_CODE = 8'h3c,  // arbitrary value
    parameter logic [7:0]   CAPACITY_CODE = 8'h0f,  // arbitrary value
    parameter logic         PROT_SCHEME   = 1'b0,
    parameter logic         EXEC_NREQ     = 1'b0,
    parameter logic         RESET_PIN     = 1'b0,
    parameter logic         ADDR_BY_BYTE  = 1'b0,
    parameter logic [1:0]   ARCH_CODE     = 2'h0,
    parameter logic [7:0]   EXT_ID2       = 8'h00,  // arbitrary value
    parameter logic [111:0] FACTORY_DATA  = '0,     // arbitrary value
    parameter logic [7:0]   ERASE4K_CODE  = 8'h5e,  // arbitrary value
    parameter logic [7:0]   OP_CLR_FLAGS  = `FID_OP_CLR_FLAGS,
    parameter logic [7:0]   OP_ID_SINGLE  = `FID_OP_ID_SINGLE,
    parameter logic [7:0]   OP_ID_MULTI   = `FID_OP_ID_MULTI,
    parameter logic [7:0]   OP_TABLE      = `FID_OP_TABLE
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  sel_n_i,
    input  wire logic                  sclk_i,
    input  wire logic [`FID_LANES-1:0] dq_i,
    input  wire fid_pkg::fid_proto_type proto_i,
    input  wire logic                  busy_i,
    output logic      [`FID_LANES-1:0] dq_o,
    output logic      [`FID_LANES-1:0] dq_oe_o,
    output logic                       clear_flags_o
);
    // two-flop synchronisers, q1 read only by q2
    logic                  sel_q1_r, sel_q2_r;
    logic                  clk_q1_r, clk_q2_r, clk_q3_r;
    logic [`FID_LANES-1:0] dq_q1_r, dq_q2_r;

    fid_pkg::fid_state_type state_r,  state_nxt;
    fid_pkg::fid_src_type   src_r,    src_nxt;
    logic [4:0]             cnt_r,    cnt_nxt;
    logic [23:0]            sh_r,     sh_nxt;
    logic [`FID_TBL_AW-1:0] ptr_r,    ptr_nxt;
    logic [7:0]             out_r,    out_nxt;
    logic [3:0]             obits_r,  obits_nxt;
    logic [`FID_LANES-1:0]  dq_r,     dq_nxt;
    logic [`FID_LANES-1:0]  oe_r,     oe_nxt;
    logic                   clr_r,    clr_nxt;

    logic       rise, fall;
    logic [2:0] in_w, out_w;
    logic [4:0] dummy_cnt;
    logic [7:0] rom_q, cur_byte, byte_w;
    logic       cmd_done;

    function automatic logic [2:0] lanes(input fid_pkg::fid_proto_type p);
        unique case (p)
            fid_pkg::FID_PROTO_EXT:  lanes = 3'h1;
            fid_pkg::FID_PROTO_DUAL: lanes = 3'h2;
            fid_pkg::FID_PROTO_QUAD: lanes = 3'h4;
            default:                 lanes = 3'h1;
        endcase
    endfunction : lanes

    function automatic logic [23:0] shift_in(input logic [23:0] s, input logic [3:0] d, input logic [2:0] w);
        unique case (w)
            3'h4:    shift_in = {s[19:0], d[3:0]};
            3'h2:    shift_in = {s[21:0], d[1:0]};
            default: shift_in = {s[22:0], d[0]};
        endcase
    endfunction : shift_in

    function automatic logic [7:0] ident_byte(input logic [`FID_TBL_AW-1:0] i, input logic multi);
        logic [3:0] k;
        k = 4'(i - 11'h005);
        ident_byte = `FID_ID_PAST;
        if (i < (multi ? `FID_ID_LEN_MULTI : `FID_ID_LEN_SINGLE)) begin
            unique case (i)
                11'h000: ident_byte = MANUF_CODE;
                11'h001: ident_byte = MEM_TYPE_CODE;
                11'h002: ident_byte = CAPACITY_CODE;
                11'h003: ident_byte = `FID_UID_LEN_BYTE;
                11'h004: ident_byte = {2'h0, PROT_SCHEME, EXEC_NREQ, RESET_PIN, ADDR_BY_BYTE, ARCH_CODE};
                11'h005: ident_byte = EXT_ID2;
                default: ident_byte = FACTORY_DATA[8'(8'd111 - {k - 4'h1, 3'h0}) -: 8];
            endcase
        end
    endfunction : ident_byte

    fid_table_rom #(
        .ERASE4K_CODE (ERASE4K_CODE)
    ) u_rom (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .addr_i  (ptr_r),
        .data_o  (rom_q)
    );

    assign rise      = clk_q2_r & ~clk_q3_r;
    assign fall      = ~clk_q2_r & clk_q3_r;
    assign in_w      = lanes(proto_i);
    assign dummy_cnt = (proto_i == fid_pkg::FID_PROTO_QUAD) ? `FID_DUMMY_QUAD : `FID_DUMMY_STD;
    assign out_w     = (src_r == fid_pkg::FID_SRC_ID_SINGLE) ? 3'h1 :
                       (src_r == fid_pkg::FID_SRC_ID_MULTI)  ? 3'h2 : in_w;
    assign cur_byte  = (src_r == fid_pkg::FID_SRC_TABLE) ? rom_q :
                       ident_byte(ptr_r, src_r == fid_pkg::FID_SRC_ID_MULTI);
    assign byte_w    = (obits_r == 4'h0) ? cur_byte : out_r;
    assign cmd_done  = !sel_q2_r && rise && state_r == fid_pkg::FID_ST_CMD &&
                       5'(cnt_r + {2'h0, in_w}) == `FID_CMD_BITS;

    always_comb begin
        state_nxt = state_r;
        src_nxt   = src_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        ptr_nxt   = ptr_r;
        out_nxt   = out_r;
        obits_nxt = obits_r;
        dq_nxt    = dq_r;
        oe_nxt    = oe_r;
        clr_nxt   = 1'b0;
        if (sel_q2_r) begin
            state_nxt = fid_pkg::FID_ST_CMD;
            cnt_nxt   = 5'h00;
            obits_nxt = 4'h0;
            oe_nxt    = '0;
        end else if (rise) begin
            unique case (state_r)
                fid_pkg::FID_ST_CMD: begin
                    sh_nxt  = shift_in(sh_r, dq_q2_r, in_w);
                    cnt_nxt = 5'(cnt_r + {2'h0, in_w});
                    if (cmd_done) begin
                        state_nxt = fid_pkg::FID_ST_IGNORE;
                        cnt_nxt   = 5'h00;
                        ptr_nxt   = '0;
                        if (sh_nxt[7:0] == OP_CLR_FLAGS) begin
                            clr_nxt = 1'b1;
                        end else if (sh_nxt[7:0] == OP_ID_SINGLE && !busy_i &&
                                     proto_i == fid_pkg::FID_PROTO_EXT) begin
                            state_nxt = fid_pkg::FID_ST_DATA;
                            src_nxt   = fid_pkg::FID_SRC_ID_SINGLE;
                        end else if (sh_nxt[7:0] == OP_ID_MULTI && !busy_i &&
                                     proto_i != fid_pkg::FID_PROTO_EXT) begin
                            state_nxt = fid_pkg::FID_ST_DATA;
                            src_nxt   = fid_pkg::FID_SRC_ID_MULTI;
                        end else if (sh_nxt[7:0] == OP_TABLE) begin
                            state_nxt = fid_pkg::FID_ST_ADDR;
                        end
                    end
                end
                fid_pkg::FID_ST_ADDR: begin
                    sh_nxt  = shift_in(sh_r, dq_q2_r, in_w);
                    cnt_nxt = 5'(cnt_r + {2'h0, in_w});
                    if (cnt_nxt == `FID_ADDR_BITS) begin
                        ptr_nxt   = sh_nxt[`FID_TBL_AW-1:0];
                        cnt_nxt   = 5'h00;
                        state_nxt = fid_pkg::FID_ST_DUMMY;
                    end
                end
                fid_pkg::FID_ST_DUMMY: begin
                    cnt_nxt = 5'(cnt_r + 5'h01);
                    if (cnt_nxt == dummy_cnt) begin
                        state_nxt = fid_pkg::FID_ST_DATA;
                        src_nxt   = fid_pkg::FID_SRC_TABLE;
                    end
                end
                fid_pkg::FID_ST_DATA, fid_pkg::FID_ST_IGNORE: begin
                end
                default: state_nxt = fid_pkg::FID_ST_IGNORE;
            endcase
        end else if (fall && state_r == fid_pkg::FID_ST_DATA) begin
            dq_nxt = '0;
            unique case (out_w)
                3'h4: begin
                    dq_nxt = byte_w[7:4];
                    oe_nxt = 4'hf;
                end
                3'h2: begin
                    dq_nxt[1:0] = byte_w[7:6];
                    oe_nxt      = 4'h3;
                end
                default: begin
                    if (src_r == fid_pkg::FID_SRC_ID_SINGLE) begin
                        dq_nxt[0] = byte_w[7];
                        oe_nxt    = 4'h1;
                    end else begin
                        dq_nxt[1] = byte_w[7];
                        oe_nxt    = 4'h2;
                    end
                end
            endcase
            out_nxt   = byte_w << out_w;
            obits_nxt = 4'(((obits_r == 4'h0) ? `FID_BYTE_BITS : obits_r) - {1'b0, out_w});
            if (obits_nxt == 4'h0) begin
                // no burst wrap: pointer just counts and rolls at table size
                ptr_nxt = `FID_TBL_AW'(ptr_r + 1'b1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sel_q1_r <= 1'b1;
            sel_q2_r <= 1'b1;
            clk_q1_r <= 1'b0;
            clk_q2_r <= 1'b0;
            clk_q3_r <= 1'b0;
            dq_q1_r  <= '0;
            dq_q2_r  <= '0;
            state_r  <= fid_pkg::FID_ST_CMD;
            src_r    <= fid_pkg::FID_SRC_ID_SINGLE;
            cnt_r    <= 5'h00;
            sh_r     <= 24'h000000;
            ptr_r    <= '0;
            out_r    <= 8'h00;
            obits_r  <= 4'h0;
            dq_r     <= '0;
            oe_r     <= '0;
            clr_r    <= 1'b0;
        end else begin
            sel_q1_r <= sel_n_i;
            sel_q2_r <= sel_q1_r;
            clk_q1_r <= sclk_i;
            clk_q2_r <= clk_q1_r;
            clk_q3_r <= clk_q2_r;
            dq_q1_r  <= dq_i;
            dq_q2_r  <= dq_q1_r;
            state_r  <= state_nxt;
            src_r    <= src_nxt;
            cnt_r    <= cnt_nxt;
            sh_r     <= sh_nxt;
            ptr_r    <= ptr_nxt;
            out_r    <= out_nxt;
            obits_r  <= obits_nxt;
            dq_r     <= dq_nxt;
            oe_r     <= oe_nxt;
            clr_r    <= clr_nxt;
        end
    end

    assign dq_o          = dq_r;
    assign dq_oe_o       = oe_r;
    assign clear_flags_o = clr_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_clear_pulse: assert property (cmd_done && sh_nxt[7:0] == OP_CLR_FLAGS
                                    |=> clear_flags_o ##1 !clear_flags_o)
        else $error("flag clear not pulsed for one cycle");
    a_clear_cause: assert property ($rose(clear_flags_o) |-> $past(cmd_done))
        else $error("flag clear without command");
    a_busy_block: assert property (cmd_done && busy_i &&
                                   (sh_nxt[7:0] == OP_ID_SINGLE || sh_nxt[7:0] == OP_ID_MULTI)
                                   |=> state_r == fid_pkg::FID_ST_IGNORE)
        else $error("identification decoded while busy");
    a_sel_release: assert property (sel_q2_r |=> dq_oe_o == 4'h0 && state_r == fid_pkg::FID_ST_CMD)
        else $error("output still driven after select high");
    a_single_ext: assert property (cmd_done && sh_nxt[7:0] == OP_ID_SINGLE &&
                                   proto_i != fid_pkg::FID_PROTO_EXT |=> state_r == fid_pkg::FID_ST_IGNORE)
        else $error("single-lane identification accepted outside extended");
    a_multi_lanes: assert property (src_r == fid_pkg::FID_SRC_ID_MULTI && dq_oe_o != 4'h0
                                    |-> dq_oe_o == 4'h3)
        else $error("multi-lane identification not on two lanes");
    a_manuf_first: assert property (src_r == fid_pkg::FID_SRC_ID_SINGLE && !sel_q2_r && fall &&
                                    state_r == fid_pkg::FID_ST_DATA && ptr_r == 11'h000 && obits_r == 4'h0
                                    |=> dq_o[0] == MANUF_CODE[7])
        else $error("manufacturer code not first");
    a_multi_stop: assert property (src_r == fid_pkg::FID_SRC_ID_MULTI && !sel_q2_r && fall &&
                                   state_r == fid_pkg::FID_ST_DATA && ptr_r >= 11'h003 && obits_r == 4'h0
                                   |=> dq_o[1:0] == 2'h0)
        else $error("multi-lane identification sent unique field");
    a_dummy_len: assert property ($rose(state_r == fid_pkg::FID_ST_DATA) &&
                                  src_r == fid_pkg::FID_SRC_TABLE |-> $past(cnt_r) == 5'(dummy_cnt - 5'h01))
        else $error("dummy clock count wrong");
    a_addr_wrap: assert property (state_r == fid_pkg::FID_ST_DATA && !sel_q2_r && fall &&
                                  ptr_r == 11'h7ff && obits_nxt == 4'h0 |=> ptr_r == 11'h000)
        else $error("table address did not wrap");

    c_clear:  cover property (clear_flags_o);
    c_uid:    cover property (src_r == fid_pkg::FID_SRC_ID_SINGLE && ptr_r == 11'h013 && dq_oe_o == 4'h1);
    c_quad:   cover property (src_r == fid_pkg::FID_SRC_TABLE && dq_oe_o == 4'hf);
    c_wrap:   cover property (src_r == fid_pkg::FID_SRC_TABLE && $past(ptr_r) == 11'h7ff && ptr_r == 11'h000);

endmodule : fid_readout

//--- fid_readout_tb_top.sv
// Purpose: self-checking bench of flag clear, identification and table reads
// Assumes: host model owns select, serial clock and lanes
// Notes:   expected bytes come from the bench's own table copies
`timescale 1ns/100ps
`include "fid_defs.svh"
module fid_readout_tb_top;
    localparam logic [111:0] FD  = 112'h0102030405060708090a0b0c0d0e;
    localparam logic [127:0] HDR = 128'h53464450000100ff00000109300000ff;
    localparam logic [287:0] PRM = {128'he55ef1ffffffff0129eb276b083b27bb,
                                    128'hffffffffffff27bbffff29eb0c5e10d8, 32'h0};
    logic                   clk;
    logic                   rst_n = 1'b0;
    fid_pkg::fid_proto_type proto = fid_pkg::FID_PROTO_EXT;
    logic                   busy  = 1'b0;
    logic                   sel_n, sclk, clr;
    logic [3:0]             dq, dq_o, dq_oe, oe_seen;
    int                     n_fail = 0;
    int                     compares = 0;
    int                     n_clr = 0;
    fid_readout #(.EXEC_NREQ(1'b1), .ARCH_CODE(2'h1), .EXT_ID2(8'ha5), .FACTORY_DATA(FD)) DUT (
        .clk_i         (clk),
        .rst_n_i       (rst_n),
        .sel_n_i       (sel_n),
        .sclk_i        (sclk),
        .dq_i          (dq),
        .proto_i       (proto),
        .busy_i        (busy),
        .dq_o          (dq_o),
        .dq_oe_o       (dq_oe),
        .clear_flags_o (clr)
    );
    fid_host_model host (
        .dut_dq_i  (dq_o),
        .dut_oe_i  (dq_oe),
        .sel_n_o   (sel_n),
        .sclk_o    (sclk),
        .dq_o      (dq),
        .oe_seen_o (oe_seen)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always_ff @(posedge clk) if (clr === 1'b1) n_clr <= n_clr + 1;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic int lanes(input fid_pkg::fid_proto_type p);
        return (p == fid_pkg::FID_PROTO_QUAD) ? 4 : (p == fid_pkg::FID_PROTO_DUAL) ? 2 : 1;
    endfunction : lanes
    function automatic logic [7:0] exp_id(input int k);
        logic [7:0] fixed [6] = '{8'h5a, 8'h3c, 8'h0f, 8'h10, 8'h11, 8'ha5};
        if (k < 6) return fixed[k];
        if (k < 20) return FD[8*(19-k) +: 8];
        return 8'h00;
    endfunction : exp_id
    function automatic logic [7:0] exp_tbl(input int a);
        if (a < 16) return HDR[8*(15-a) +: 8];
        if (a < 48 || a > 83) return 8'hff;
        return PRM[8*(83-a) +: 8];
    endfunction : exp_tbl
    task automatic set_mode(input int p, input logic b);
        @(negedge clk);
        proto = fid_pkg::fid_proto_type'(p);
        busy  = b;
    endtask : set_mode
    // busy on the quad pass: clearing is never refused
    task automatic t_clear();
        int          n0;
        logic [31:0] r;
        for (int i = 0; i < 3; i++) begin
            set_mode(i, i == 2);
            n0 = n_clr;
            host.open_frame();
            host.clocks(`FID_OP_CLR_FLAGS, 8 / lanes(proto), lanes(proto), 1, 0, r);
            host.close_frame();
            check("clear pulses", n_clr - n0, 1);
        end
    endtask : t_clear
    task automatic t_ident_single();
        logic [31:0] r;
        set_mode(0, 1'b0);
        host.open_frame();
        host.clocks(`FID_OP_ID_SINGLE, 8, 1, 1, 0, r);
        for (int k = 0; k < 21; k++) begin
            host.clocks(0, 8, 0, 1, 0, r);
            check("ident byte", r, exp_id(k));
        end
        check("ident lanes", oe_seen, 4'h1);
        host.close_frame();
    endtask : t_ident_single
    // ends mid-byte to see the drive drop at select
    task automatic t_ident_multi(input int p);
        logic [31:0] r;
        set_mode(p, 1'b0);
        host.open_frame();
        host.clocks(`FID_OP_ID_MULTI, 8 / lanes(proto), lanes(proto), 2, 0, r);
        for (int k = 0; k < 4; k++) begin
            host.clocks(0, 4, 0, 2, 0, r);
            check("multi ident byte", r, (k < 3) ? exp_id(k) : 8'h00);
        end
        host.clocks(0, 2, 0, 2, 0, r);
        check("ident lanes", oe_seen, 4'h3);
        host.close_frame();
        check("drive after select", dq_oe, 4'h0);
    endtask : t_ident_multi
    task automatic t_refused();
        logic [7:0]  ops [4] = '{`FID_OP_ID_SINGLE, `FID_OP_ID_MULTI, `FID_OP_ID_SINGLE, `FID_OP_ID_MULTI};
        int          prs [4] = '{1, 0, 0, 2};
        logic [31:0] r;
        int          n0;
        for (int i = 0; i < 4; i++) begin
            set_mode(prs[i], i > 1);
            n0 = n_clr;
            host.open_frame();
            host.clocks(ops[i], 8 / lanes(proto), lanes(proto), 1, 0, r);
            host.clocks(0, 16, 0, 1, 0, r);
            host.close_frame();
            check("refused drive", oe_seen, 4'h0);
            check("refused side effect", n_clr - n0, 0);
        end
    endtask : t_refused
    task automatic t_table(input int p, input int addr, input int nb);
        logic [31:0] r;
        int          w;
        int          a;
        set_mode(p, 1'b0);
        w = lanes(proto);
        host.open_frame();
        host.clocks(`FID_OP_TABLE, 8 / w, w, 1, 0, r);
        host.clocks(addr, 24 / w, w, 1, 0, r);
        host.clocks(0, (p == 2) ? 10 : 8, 0, 1, 0, r);
        for (int k = 0; k < nb; k++) begin
            host.clocks(0, 8 / w, 0, w, (p == 0) ? 1 : 0, r);
            a = (addr + k) % 2048;
            if (a < 16) check("table head", r, exp_tbl(a));
            else if (a < 48 || a > 83) check("table fill", r, exp_tbl(a));
            else check("table param", r, exp_tbl(a));
        end
        host.close_frame();
    endtask : t_table
    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_clear();
        t_ident_single();
        t_ident_multi(1);
        t_ident_multi(2);
        t_refused();
        t_table(0, 'h02e, 4);
        t_table(1, 'h7fe, 4);
        t_table(2, 'h000, 96);
        tally_and_finish();
    end
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
endmodule : fid_readout_tb_top

//--- fid_table_rom.sv
// Purpose: discovery parameter table, registered read
// Assumes: address is stable for a cycle before data is used
// Notes:   table is 2048 bytes; undefined locations read erased
`timescale 1ns/100ps
`include "fid_defs.svh"
module fid_table_rom #(
    parameter logic [7:0] ERASE4K_CODE = 8'h5e
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic [`FID_TBL_AW-1:0] addr_i,
    output logic      [7:0]             data_o
);
    localparam logic [7:0] HDR [0:`FID_TBL_HDR_CNT-1] = '{
        8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hff,
        8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff};
    localparam logic [7:0] PRM [0:`FID_TBL_PARAM_CNT-1] = '{
        8'he5, ERASE4K_CODE, 8'hf1, 8'hff,
        8'hff, 8'hff, 8'hff, 8'h01,
        8'h29, 8'heb, 8'h27, 8'h6b,
        8'h08, 8'h3b, 8'h27, 8'hbb,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h27, 8'hbb,
        8'hff, 8'hff, 8'h29, 8'heb,
        8'h0c, ERASE4K_CODE, 8'h10, 8'hd8,
        8'h00, 8'h00, 8'h00, 8'h00};

    logic [7:0] data_r;
    logic [7:0] data_nxt;

    always_comb begin
        data_nxt = `FID_FILL;
        if (addr_i <= `FID_TBL_HDR_END) begin
            data_nxt = HDR[addr_i[3:0]];
        end else if (addr_i >= `FID_TBL_PARAM_BASE && addr_i <= `FID_TBL_PARAM_END) begin
            data_nxt = PRM[6'(addr_i - `FID_TBL_PARAM_BASE)];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            data_r <= `FID_FILL;
        end else begin
            data_r <= data_nxt;
        end
    end

    assign data_o = data_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_sig_bytes: assert property (addr_i == 11'h000 |=> data_o == 8'h53 && $past(addr_i) == 11'h000)
        else $error("signature byte 0 wrong");
    a_fill_gap: assert property (addr_i > 11'h00f && addr_i < 11'h030 |=> data_o == 8'hff)
        else $error("gap location not erased value");
    a_past_end: assert property (addr_i > 11'h053 |=> data_o == 8'hff)
        else $error("undefined location not erased value");
    a_ptr_field: assert property (addr_i == 11'h00c |=> data_o == 8'h30)
        else $error("parameter table pointer wrong");
    a_sector_size: assert property (addr_i == 11'h04e |=> data_o == 8'h10)
        else $error("sector type 2 size wrong");

endmodule : fid_table_rom
